// >>> src/gwd_watchdog_unit.sv
// watchdog unit driven by hub gpio lines: kick and a three bit period select
// assumes lines synchronous to clk_sys; periods are module parameters
// sys_reset is a level request, held until a kick, a new code or code 011
// wd_enabled follows the select lines without a register
// each period parameter is given in clk_sys cycles
//
// Operation
// - timeout is selectable from 1 ms up to 1 minute.
// - while enabled, expiry without restart asserts system reset.
// - inputs are one kick line and three period select lines from the hub.
// - code 000..111 maps to 1ms,10ms,30ms,off,100ms,1s,10s,1min.
// - code 011 disables and is the default; timing starts on other codes.
`timescale 1ns/10ps
module gwd_watchdog_unit #(
  parameter longint unsigned P_1MS = gwd_pkg::CYC_1MS,
  parameter longint unsigned P_10MS = gwd_pkg::CYC_10MS,
  parameter longint unsigned P_30MS = gwd_pkg::CYC_30MS,
  parameter longint unsigned P_100MS = gwd_pkg::CYC_100MS,
  parameter longint unsigned P_1S = gwd_pkg::CYC_1S,
  parameter longint unsigned P_10S = gwd_pkg::CYC_10S,
  parameter longint unsigned P_1MIN = gwd_pkg::CYC_1MIN
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire gwd_pkg::gwd_ctrl_s ctrl,
  output logic sys_reset,
  output logic wd_enabled
);

  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  // span of the count register; each limit must sit inside it
  localparam longint unsigned CNT_SPAN = 64'd1 << gwd_pkg::CNT_W;

  // each period nonzero and inside the span
  if (P_1MS == 64'd0 || P_1MS >= CNT_SPAN) begin : g_bad_1ms
    $error("1 ms period out of counter range");
  end
  if (P_10MS == 64'd0 || P_10MS >= CNT_SPAN) begin : g_bad_10ms
    $error("10 ms period out of counter range");
  end
  if (P_30MS == 64'd0 || P_30MS >= CNT_SPAN) begin : g_bad_30ms
    $error("30 ms period out of counter range");
  end
  if (P_100MS == 64'd0 || P_100MS >= CNT_SPAN) begin : g_bad_100ms
    $error("100 ms period out of counter range");
  end
  if (P_1S == 64'd0 || P_1S >= CNT_SPAN) begin : g_bad_1s
    $error("1 s period out of counter range");
  end
  if (P_10S == 64'd0 || P_10S >= CNT_SPAN) begin : g_bad_10s
    $error("10 s period out of counter range");
  end
  if (P_1MIN == 64'd0 || P_1MIN >= CNT_SPAN) begin : g_bad_1min
    $error("1 min period out of counter range");
  end

  // periods grow with the code, 1 ms shortest
  if (P_10MS < P_1MS) begin : g_ord_10ms
    $error("10 ms period below 1 ms period");
  end
  if (P_30MS < P_10MS) begin : g_ord_30ms
    $error("30 ms period below 10 ms period");
  end
  if (P_100MS < P_30MS) begin : g_ord_100ms
    $error("100 ms period below 30 ms period");
  end
  if (P_1S < P_100MS) begin : g_ord_1s
    $error("1 s period below 100 ms period");
  end
  if (P_10S < P_1S) begin : g_ord_10s
    $error("10 s period below 1 s period");
  end
  if (P_1MIN < P_10S) begin : g_ord_1min
    $error("1 min period below 10 s period");
  end

  // ----------------------------------------
  // line capture
  // ----------------------------------------
  logic kick_now;
  logic [2:0] sel_now;

  // one kick line, three select lines
  // fields split out so the logic reads by name
  assign kick_now = ctrl.kick_line;
  assign sel_now = ctrl.period_sel;

  // ----------------------------------------
  // period decode
  // ----------------------------------------
  logic [gwd_pkg::CNT_W-1:0] limit;

  always_comb begin
    case (gwd_pkg::gwd_sel_e'(sel_now))
      gwd_pkg::SEL_1MS: limit = P_1MS[gwd_pkg::CNT_W-1:0];
      gwd_pkg::SEL_10MS: limit = P_10MS[gwd_pkg::CNT_W-1:0];
      gwd_pkg::SEL_30MS: limit = P_30MS[gwd_pkg::CNT_W-1:0];
      gwd_pkg::SEL_100MS: limit = P_100MS[gwd_pkg::CNT_W-1:0];
      gwd_pkg::SEL_1S: limit = P_1S[gwd_pkg::CNT_W-1:0];
      gwd_pkg::SEL_10S: limit = P_10S[gwd_pkg::CNT_W-1:0];
      gwd_pkg::SEL_1MIN: limit = P_1MIN[gwd_pkg::CNT_W-1:0];
      // off code has no period; en keeps the count idle
      default: limit = '0;
    endcase
  end

  // ----------------------------------------
  // enable
  // ----------------------------------------
  logic en;

  // code 011 is off, every other code runs
  // no register, so the off code takes hold at once
  assign en = sel_now != gwd_pkg::SEL_OFF;

  // ----------------------------------------
  // sampled lines
  // ----------------------------------------
  logic kick_q, kick_d;
  logic [2:0] sel_q, sel_d;

  // previous levels, for edge and change detection
  always_comb begin
    kick_d = kick_now;
    sel_d = sel_now;
  end

  // reset value is the off code
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      kick_q <= gwd_pkg::KICK_RST;
      sel_q <= gwd_pkg::SEL_RST;
    end else begin
      kick_q <= kick_d;
      sel_q <= sel_d;
    end
  end

  // ----------------------------------------
  // restart and expiry
  // ----------------------------------------
  // one, at the counter width
  localparam logic [gwd_pkg::CNT_W-1:0] CNT_ONE =
    {{(gwd_pkg::CNT_W-1){1'b0}}, 1'b1};

  logic [gwd_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic kick_edge;
  logic sel_change;
  logic restart;
  logic [gwd_pkg::CNT_W-1:0] cnt_inc;
  logic expire;

  assign kick_edge = kick_now != kick_q;
  // a new code restarts with its own period
  assign sel_change = sel_now != sel_q;
  // restart wins over expiry in the same cycle
  assign restart = kick_edge || sel_change;

  // expiry once the count would reach the limit
  assign cnt_inc = cnt_q + CNT_ONE;
  assign expire = cnt_inc >= limit;

  // ----------------------------------------
  // period counter
  // ----------------------------------------
  // count runs while enabled, stops at expiry
  always_comb begin
    cnt_d = cnt_q;
    if (!en || restart) begin
      // idle or restarted count sits at zero
      cnt_d = '0;
    end else if (!expire) begin
      cnt_d = cnt_inc;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------
  // reset request
  // ----------------------------------------
  logic rst_q, rst_d;

  always_comb begin
    rst_d = rst_q;
    if (!en || restart) begin
      // off or restarted clears the request
      rst_d = 1'b0;
    end else if (expire) begin
      // missed kick, request held until restart
      rst_d = 1'b1;
    end
  end

  // held level, not a pulse
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_q <= 1'b0;
    end else begin
      rst_q <= rst_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // request straight from a flip-flop
  assign sys_reset = rst_q;

  assign wd_enabled = en;

endmodule

// >>> src/gwd_pkg.sv
// package for the gpio controlled watchdog: select codes, periods, counts
// assumes a 200 MHz system clock
package gwd_pkg;

  // ----------------------------------------
  // clock
  // ----------------------------------------
  localparam longint unsigned CLK_HZ = 64'd200_000_000;

  // ----------------------------------------
  // timeout periods in microseconds
  // ----------------------------------------
  localparam longint unsigned T_1MS_US = 64'd1_000;
  localparam longint unsigned T_10MS_US = 64'd10_000;
  localparam longint unsigned T_30MS_US = 64'd30_000;
  localparam longint unsigned T_100MS_US = 64'd100_000;
  localparam longint unsigned T_1S_US = 64'd1_000_000;
  localparam longint unsigned T_10S_US = 64'd10_000_000;
  localparam longint unsigned T_1MIN_US = 64'd60_000_000;

  localparam int CNT_W = 34;

  // each time rounds down, never below one cycle
  function automatic longint unsigned us_to_cyc(longint unsigned us);
    longint unsigned c;
    c = (us * CLK_HZ) / 64'd1_000_000;
    return (c == 64'd0) ? 64'd1 : c;
  endfunction

  localparam longint unsigned CYC_1MS = us_to_cyc(T_1MS_US);
  localparam longint unsigned CYC_10MS = us_to_cyc(T_10MS_US);
  localparam longint unsigned CYC_30MS = us_to_cyc(T_30MS_US);
  localparam longint unsigned CYC_100MS = us_to_cyc(T_100MS_US);
  localparam longint unsigned CYC_1S = us_to_cyc(T_1S_US);
  localparam longint unsigned CYC_10S = us_to_cyc(T_10S_US);
  localparam longint unsigned CYC_1MIN = us_to_cyc(T_1MIN_US);

  // ----------------------------------------
  // select codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    SEL_1MS = 3'b000,
    SEL_10MS = 3'b001,
    SEL_30MS = 3'b010,
    SEL_OFF = 3'b011,
    SEL_100MS = 3'b100,
    SEL_1S = 3'b101,
    SEL_10S = 3'b110,
    SEL_1MIN = 3'b111
  } gwd_sel_e;

  localparam logic [2:0] SEL_RST = 3'h3;
  localparam logic KICK_RST = 1'h0;

  // ----------------------------------------
  // control lines from the hub
  // ----------------------------------------
  typedef struct packed {
    logic kick_line;
    logic [2:0] period_sel;
  } gwd_ctrl_s;

endpackage

// >>> tb/gwd_monitor.sv
// port checker for the watchdog unit
// assumes short periods, 10 cycles for code 000
`timescale 1ns/10ps
module gwd_monitor (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire gwd_pkg::gwd_ctrl_s ctrl,
  input wire logic sys_reset,
  input wire logic wd_enabled
);
  // cycles for code 000 in the bench build
  localparam int QUIET_1MS = 10;
  gwd_pkg::gwd_ctrl_s last_q;
  logic [7:0] quiet_q;
  // helper: edges since ctrl last changed, saturating
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      last_q <= {gwd_pkg::KICK_RST, gwd_pkg::SEL_RST};
      quiet_q <= 8'h00;
    end else begin
      last_q <= ctrl;
      if (ctrl != last_q) begin
        quiet_q <= 8'h00;
      end else if (quiet_q != 8'hff) begin
        quiet_q <= quiet_q + 8'h01;
      end
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  en_decode_a: assert property (
    wd_enabled == (ctrl.period_sel != 3'h3)) else $error("bad enable");
  off_quiet_a: assert property (
    ctrl.period_sel == 3'h3 |=> !sys_reset) else $error("reset while off");
  restart_a: assert property (
    $changed(ctrl) |=> !sys_reset) else $error("no restart");
  rise_cause_a: assert property (
    $rose(sys_reset) |-> $past(wd_enabled)) else $error("reset when off");
  hold_high_a: assert property (
    sys_reset && $stable(ctrl) |=> sys_reset) else $error("reset dropped");
  early_fire_a: assert property (
    last_q.period_sel == 3'h0 && quiet_q < QUIET_1MS |-> !sys_reset)
    else $error("early timeout");
  late_fire_a: assert property (
    last_q.period_sel == 3'h0 && quiet_q == QUIET_1MS |-> sys_reset)
    else $error("missed timeout");
  cover property ($rose(sys_reset));
  cover property ($fell(wd_enabled));
  cover property ($changed(ctrl.kick_line) && wd_enabled);
endmodule
bind gwd_watchdog_unit gwd_monitor mon (.clk_sys(clk_sys), .rst_b(rst_b),
  .ctrl(ctrl), .sys_reset(sys_reset), .wd_enabled(wd_enabled));

// >>> tb/gwd_host.sv
// hub gpio model: kick line and period select
// assumes lines change by nba at the rising edge
`timescale 1ns/10ps
module gwd_host (
  input wire logic clk_sys,
  output gwd_pkg::gwd_ctrl_s ctrl
);
  initial ctrl = {1'h0, 3'h3};
  task automatic set_sel(input logic [2:0] sel);
    @(posedge clk_sys);
    ctrl.period_sel <= sel;
  endtask
  task automatic kick();
    @(posedge clk_sys);
    ctrl.kick_line <= ~ctrl.kick_line;
  endtask
endmodule

// >>> tb/gpio_controlled_watchdog_bench.sv
// bench for the watchdog unit
// assumes periods shortened to 10..70 cycles
`timescale 1ns/10ps
module gpio_controlled_watchdog_bench;
  logic clk_sys, rst_b, sys_reset, wd_enabled;
  gwd_pkg::gwd_ctrl_s ctrl;
  int n_fail = 0;
  int samples_checked = 0;
  int n;
  gwd_host host (.clk_sys(clk_sys), .ctrl(ctrl));
  // periods cut to steps of TICK cycles
  localparam longint unsigned TICK = 64'd10;
  gwd_watchdog_unit #(.P_1MS(TICK), .P_10MS(2 * TICK), .P_30MS(3 * TICK),
    .P_100MS(4 * TICK), .P_1S(5 * TICK), .P_10S(6 * TICK),
    .P_1MIN(7 * TICK)) dut (.clk_sys(clk_sys),
    .rst_b(rst_b), .ctrl(ctrl), .sys_reset(sys_reset),
    .wd_enabled(wd_enabled));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %0d want %0d", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // edges until the reset request shows
  task automatic wait_rst(output int c);
    c = 0;
    do begin
      @(posedge clk_sys);
      #1;
      c++;
    end while (sys_reset !== 1'h1 && c < 200);
    if (c == 200) begin
      n_fail++;
      print_verdict();
    end
  endtask
  initial begin
    clk_sys = 1'h0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    rst_b = 1'h0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'h1;
    #1;
    check({wd_enabled, sys_reset}, 0);
    for (int i = 0; i < 7; i++) begin
      host.set_sel(3'(i + (i > 2)));
      wait_rst(n);
      check(n, 10 * i + 11);
    end
    host.set_sel(3'h0);
    repeat (5) @(posedge clk_sys);
    host.kick();
    wait_rst(n);
    check(n, 11);
    check({wd_enabled, sys_reset}, 3);
    host.set_sel(3'h3);
    repeat (80) @(posedge clk_sys);
    #1;
    check({wd_enabled, sys_reset}, 0);
    print_verdict();
  end
endmodule
